// *** wt_top.sv ***
// wake-up timer with rc calibration, duty-cycle receive control and battery monitor
//
// Behaviour
// - timer clock is the internal 32 kHz rc or an external 32 kHz crystal
// - with the enable bit set, the timer counts the mantissa/exponent period
// - period equals mantissa times 4*2^exponent over 32.768 ms
// - on expiry interrupt_request_n goes low if the wake interrupt is enabled
// - rc oscillator is calibrated on boot and on leaving shutdown
// - periodic recalibration only when enabled, interval from a three-bit field
// - recalibration starts the crystal, compares rc against 30 MHz, trims rc
// - receive window equals window count times 4*2^exponent over 32.768 ms
// - each duty-cycle wake enters receive, returns at window end without packet
// - preamble or sync seen in the window extends the window for the packet
// - after two windows without a packet, return and wait for next wake
// - battery monitor works only with its enable and the wake timer enabled
// - battery is compared with threshold at every timer expiry
// - threshold code decodes in 50 mV steps from 1.5 V to 3.05 V
// - low battery shows as interrupt or as a direct general-purpose pin
`default_nettype none
`include "wt_defines.svh"

module wt_top #(
  parameter int EXP_W  = 5,
  parameter int MANT_W = 16,
  parameter int WIN_W  = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              rc_clk_in,
  input  wire logic              xtal32_clk_in,
  input  wire logic              clock_source_select,
  input  wire logic              wake_timer_enable_bit,
  input  wire logic [EXP_W-1:0]  wake_period_exponent,
  input  wire logic [MANT_W-1:0] wake_period_mantissa,
  input  wire logic              wake_int_enable,
  input  wire logic              battery_int_enable,
  input  wire logic              battery_to_gpio,
  input  wire logic              duty_cycle_receive,
  input  wire logic [WIN_W-1:0]  receive_window_count,
  input  wire logic              battery_monitor_enable,
  input  wire logic [4:0]        battery_threshold_setting,
  input  wire logic [11:0]       supply_mv,
  input  wire logic              boot_cmd,
  input  wire logic              shutdown_exit,
  input  wire logic              recal_enable,
  input  wire logic [2:0]        recalibration_interval_field,
  input  wire logic              xo_ready_in,
  input  wire logic              xo_ref_clk_in,
  input  wire logic              preamble_or_sync_detect,
  input  wire logic              packet_received,
  input  wire logic              interrupt_status_clear,
  output logic                   interrupt_request_n,
  output logic                   wake_timer_flag,
  output logic                   battery_low_flag,
  output logic                   battery_low_gpio,
  output logic                   rx_enable,
  output logic                   xtal_osc_enable,
  output logic [6:0]             rc_trim,
  output logic                   calibrating
);
  localparam logic [15:0] REF_EXPECT = 16'(`WT_CAL_REF_EXPECT);
  localparam logic [15:0] REF_TOL    = 16'(`WT_CAL_TOLERANCE);

  // ----------------------------------------------------------------------------
  // pin synchronisers: rc, crystal, xo ready, reference clock
  // ----------------------------------------------------------------------------
  wire  logic [3:0] pin_raw;
  wire  logic [3:0] pin_s2;
  wire  logic [3:0] pin_rise;

  assign pin_raw = {xo_ref_clk_in, xo_ready_in, xtal32_clk_in, rc_clk_in};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      // each lane owns its flops, so no vector has several clocked writers
      logic s1;
      logic s2;
      logic s3;

      // first stage feeds only the second, so metastability stays contained
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end else begin
          s1 <= pin_raw[gi];
          s2 <= s1;
          s3 <= s2;
        end
      end
      assign pin_s2[gi]   = s2;
      assign pin_rise[gi] = s2 && !s3;
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // slow clock source selection and unit divider
  // ----------------------------------------------------------------------------
  wire logic rc_tick;
  wire logic ref_edge;
  wire logic xo_ready;
  wire logic lf_tick;

  assign rc_tick  = pin_rise[0];
  assign ref_edge = pin_rise[3];
  assign xo_ready = pin_s2[2];
  assign lf_tick  = clock_source_select ? pin_rise[1] : rc_tick;

  wt_tick_if #(.EXP_W(EXP_W)) tk ();
  assign tk.tick     = lf_tick && wake_timer_enable_bit;
  assign tk.clear    = !wake_timer_enable_bit;
  assign tk.exponent = wake_period_exponent;

  wt_unit_div #(.EXP_W(EXP_W)) u_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .t       (tk)
  );

  // ----------------------------------------------------------------------------
  // wake period counter; a zero mantissa never expires
  // ----------------------------------------------------------------------------
  logic [MANT_W-1:0] period_cnt;
  wire  logic        expire;

  assign expire = tk.unit && (wake_period_mantissa != '0)
                  && (period_cnt == wake_period_mantissa - MANT_W'(1));

  always_ff @(posedge sys_clk) begin
    if (rst || !wake_timer_enable_bit) begin
      period_cnt <= '0;
    end else if (expire) begin
      period_cnt <= '0;
    end else if (tk.unit) begin
      period_cnt <= period_cnt + MANT_W'(1);
    end
  end

  // ----------------------------------------------------------------------------
  // battery monitor, compared at every expiry
  // ----------------------------------------------------------------------------
  wire logic        batt_active;
  wire logic [4:0]  thresh_code;
  wire logic [11:0] thresh_mv;
  wire logic        batt_low_now;

  assign batt_active  = battery_monitor_enable && wake_timer_enable_bit;
  assign thresh_code  = (battery_threshold_setting > 5'(`WT_BATT_MAX_CODE))
                        ? 5'(`WT_BATT_MAX_CODE) : battery_threshold_setting;
  assign thresh_mv    = 12'(`WT_BATT_BASE_MV) + 12'(thresh_code) * 12'(`WT_BATT_STEP_MV);
  assign batt_low_now = expire && batt_active && (supply_mv < thresh_mv);

  // ----------------------------------------------------------------------------
  // sticky status flags; a set in the clearing cycle wins
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wake_timer_flag  <= 1'b0;
      battery_low_flag <= 1'b0;
    end else begin
      wake_timer_flag  <= expire || (wake_timer_flag && !interrupt_status_clear);
      battery_low_flag <= batt_low_now || (battery_low_flag && !interrupt_status_clear);
    end
  end

  // low battery goes either to the interrupt or straight to the pin
  assign interrupt_request_n = !((wake_timer_flag && wake_int_enable)
                                 || (battery_low_flag && battery_int_enable
                                     && !battery_to_gpio));
  assign battery_low_gpio    = battery_to_gpio && battery_low_flag;

  // ----------------------------------------------------------------------------
  // duty-cycle receive: one window, extended once on preamble or sync
  // ----------------------------------------------------------------------------
  wt_pkg::wt_ldc_state_e ldc_state;
  logic [WIN_W-1:0]      win_cnt;
  logic                  ldc_second;
  logic                  ldc_seen;
  wire  logic            window_end;

  // a zero count must end on the first unit, not wrap to the largest count
  assign window_end = (ldc_state == wt_pkg::WT_LDC_RX) && tk.unit
                      && ((receive_window_count == '0)
                          || (win_cnt >= receive_window_count - WIN_W'(1)));
  assign rx_enable  = (ldc_state == wt_pkg::WT_LDC_RX);

  always_ff @(posedge sys_clk) begin
    if (rst || !duty_cycle_receive || !wake_timer_enable_bit) begin
      ldc_state  <= wt_pkg::WT_LDC_SLEEP;
      win_cnt    <= '0;
      ldc_second <= 1'b0;
      ldc_seen   <= 1'b0;
    end else begin
      unique case (ldc_state)
        wt_pkg::WT_LDC_SLEEP: begin
          if (expire) begin
            ldc_state  <= wt_pkg::WT_LDC_RX;
            win_cnt    <= '0;
            ldc_second <= 1'b0;
            ldc_seen   <= 1'b0;
          end
        end
        wt_pkg::WT_LDC_RX: begin
          if (preamble_or_sync_detect) ldc_seen <= 1'b1;
          if (packet_received) begin
            ldc_state <= wt_pkg::WT_LDC_SLEEP;
          end else if (window_end) begin
            win_cnt <= '0;
            if ((ldc_seen || preamble_or_sync_detect) && !ldc_second) begin
              ldc_second <= 1'b1;
            end else begin
              ldc_state <= wt_pkg::WT_LDC_SLEEP;
            end
          end else if (tk.unit) begin
            win_cnt <= win_cnt + WIN_W'(1);
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // recalibration interval in rc ticks: 2^(11+field)
  // ----------------------------------------------------------------------------
  logic [18:0] recal_cnt;
  wire  logic  recal_due;
  wire  logic  cal_request;

  assign recal_due   = recal_enable && rc_tick && (recal_cnt ==
                       (19'h0_0001 << (`WT_RECAL_BASE_SHIFT + recalibration_interval_field))
                       - 19'h0_0001);
  assign cal_request = boot_cmd || shutdown_exit || recal_due;

  always_ff @(posedge sys_clk) begin
    if (rst || !recal_enable || recal_due) begin
      recal_cnt <= '0;
    end else if (rc_tick) begin
      recal_cnt <= recal_cnt + 19'h0_0001;
    end
  end

  // ----------------------------------------------------------------------------
  // calibration: start crystal, count reference edges over rc ticks, trim
  // ----------------------------------------------------------------------------
  wt_pkg::wt_cal_state_e cal_state;
  logic [5:0]            cal_rc_cnt;
  logic [15:0]           ref_cnt;

  assign xtal_osc_enable = (cal_state != wt_pkg::WT_CAL_IDLE);
  assign calibrating     = xtal_osc_enable;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cal_state  <= wt_pkg::WT_CAL_IDLE;
      cal_rc_cnt <= '0;
      ref_cnt    <= '0;
      rc_trim    <= `WT_TRIM_RESET;
    end else begin
      unique case (cal_state)
        wt_pkg::WT_CAL_IDLE: begin
          if (cal_request) cal_state <= wt_pkg::WT_CAL_XO_WAIT;
        end
        wt_pkg::WT_CAL_XO_WAIT: begin
          cal_rc_cnt <= '0;
          ref_cnt    <= '0;
          if (xo_ready && rc_tick) cal_state <= wt_pkg::WT_CAL_MEASURE;
        end
        wt_pkg::WT_CAL_MEASURE: begin
          if (ref_edge) ref_cnt <= ref_cnt + 16'h0001;
          if (rc_tick) begin
            cal_rc_cnt <= cal_rc_cnt + 6'h01;
            if (cal_rc_cnt == 6'(`WT_CAL_RC_TICKS - 1)) cal_state <= wt_pkg::WT_CAL_ADJUST;
          end
        end
        wt_pkg::WT_CAL_ADJUST: begin
          // one step per pass keeps the trim change gentle under noise
          if (ref_cnt > REF_EXPECT + REF_TOL && rc_trim != 7'h7f) begin
            rc_trim <= rc_trim + 7'h01;
          end else if (ref_cnt + REF_TOL < REF_EXPECT && rc_trim != 7'h00) begin
            rc_trim <= rc_trim - 7'h01;
          end
          cal_state <= wt_pkg::WT_CAL_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  property p_irq_on_expire;
    @(posedge sys_clk) disable iff (rst)
    expire && wake_int_enable |=> !interrupt_request_n;
  endproperty
  a_irq_on_expire: assert property (p_irq_on_expire) else $error("no irq on expiry");

  property p_flag_holds;
    @(posedge sys_clk) disable iff (rst)
    wake_timer_flag && !interrupt_status_clear |=> wake_timer_flag;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("wake flag dropped");

  property p_reload;
    @(posedge sys_clk) disable iff (rst)
    expire |=> period_cnt == '0 && wake_timer_flag;
  endproperty
  a_reload: assert property (p_reload) else $error("period not reloaded");

  property p_boot_cal;
    @(posedge sys_clk) disable iff (rst)
    (boot_cmd || shutdown_exit) && cal_state == wt_pkg::WT_CAL_IDLE |=> xtal_osc_enable;
  endproperty
  a_boot_cal: assert property (p_boot_cal) else $error("boot did not calibrate");

  property p_recal_off;
    @(posedge sys_clk) disable iff (rst)
    !recal_enable |=> recal_cnt == '0;
  endproperty
  a_recal_off: assert property (p_recal_off) else $error("recal ran while off");

  property p_ldc_wake;
    @(posedge sys_clk) disable iff (rst)
    expire && duty_cycle_receive && ldc_state == wt_pkg::WT_LDC_SLEEP |=> rx_enable;
  endproperty
  a_ldc_wake: assert property (p_ldc_wake) else $error("no rx on wake");

  property p_extend;
    @(posedge sys_clk) disable iff (rst)
    window_end && ldc_seen && !ldc_second && !packet_received && duty_cycle_receive
      && wake_timer_enable_bit |=> rx_enable && ldc_second;
  endproperty
  a_extend: assert property (p_extend) else $error("window not extended");

  property p_two_windows;
    @(posedge sys_clk) disable iff (rst)
    window_end && ldc_second |=> !rx_enable;
  endproperty
  a_two_windows: assert property (p_two_windows) else $error("rx past two windows");

  property p_batt_low;
    @(posedge sys_clk) disable iff (rst)
    expire && batt_active && supply_mv < thresh_mv |=> battery_low_flag;
  endproperty
  a_batt_low: assert property (p_batt_low) else $error("low battery missed");

  property p_batt_off;
    @(posedge sys_clk) disable iff (rst)
    !wake_timer_enable_bit && !battery_low_flag |=> !battery_low_flag;
  endproperty
  a_batt_off: assert property (p_batt_off) else $error("battery flag without timer");
endmodule : wt_top

`default_nettype wire

// *** wt_defines.svh ***
// constants of the wake-up timer block: timing counts, field limits and reset values
`ifndef WT_DEFINES_SVH
`define WT_DEFINES_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define WT_LF_CLK_HZ        32768
`define WT_REF_CLK_HZ       30000000
`define WT_UNIT_BASE        4
`define WT_CAL_RC_TICKS     32
`define WT_CAL_REF_EXPECT   ((`WT_REF_CLK_HZ * `WT_CAL_RC_TICKS + `WT_LF_CLK_HZ / 2) / `WT_LF_CLK_HZ)
`define WT_CAL_TOLERANCE    8
`define WT_RECAL_BASE_SHIFT 11

// ----------------------------------------------------------------------------
// battery threshold decode, in millivolts
// ----------------------------------------------------------------------------
`define WT_BATT_BASE_MV     1500
`define WT_BATT_STEP_MV     50
`define WT_BATT_MAX_CODE    31

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define WT_TRIM_RESET       7'h40

`endif

// *** wt_pkg.sv ***
// types shared by the wake-up timer modules
`default_nettype none

package wt_pkg;
  typedef enum logic [1:0] {
    WT_CAL_IDLE,
    WT_CAL_XO_WAIT,
    WT_CAL_MEASURE,
    WT_CAL_ADJUST
  } wt_cal_state_e;

  typedef enum logic {
    WT_LDC_SLEEP,
    WT_LDC_RX
  } wt_ldc_state_e;
endpackage : wt_pkg

`default_nettype wire

// *** wt_tick_if.sv ***
// interface between the wake timer core and its unit divider
`default_nettype none

interface wt_tick_if #(parameter int EXP_W = 5);
  logic             tick;
  logic             clear;
  logic [EXP_W-1:0] exponent;
  logic             unit;

  modport core_side (output tick, output clear, output exponent, input unit);
  modport div_side  (input tick, input clear, input exponent, output unit);
endinterface : wt_tick_if

`default_nettype wire

// *** wt_unit_div.sv ***
// divider from 32 kHz ticks to wake units of 4 * 2^exponent ticks
`default_nettype none
`include "wt_defines.svh"

module wt_unit_div #(
  parameter int EXP_W = 5
) (
  input  wire logic    sys_clk,
  input  wire logic    rst,
  wt_tick_if.div_side  t
);
  localparam int CNT_W = EXP_W + 31;

  logic [CNT_W-1:0] count;
  wire  logic [CNT_W-1:0] unit_len;
  wire  logic             unit_last;

  // ----------------------------------------------------------------------------
  // unit length decode
  // ----------------------------------------------------------------------------
  assign unit_len  = CNT_W'(`WT_UNIT_BASE) << t.exponent;
  assign unit_last = (count == unit_len - CNT_W'(1));
  assign t.unit    = t.tick && unit_last;

  // ----------------------------------------------------------------------------
  // tick counter, restarts on clear so a new period starts aligned
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst || t.clear) begin
      count <= '0;
    end else if (t.tick) begin
      count <= unit_last ? '0 : count + CNT_W'(1);
    end
  end

  property p_unit_wraps;
    @(posedge sys_clk) disable iff (rst)
    t.unit && !t.clear |=> count == '0;
  endproperty
  a_unit_wraps: assert property (p_unit_wraps) else $error("divider did not wrap");
endmodule : wt_unit_div

`default_nettype wire

// *** wt_partner.sv ***
// behavioural model of the oscillators around the wake-up timer
`default_nettype none

module wt_partner #(
  parameter int RC_HALF  = 4,
  parameter int XT_HALF  = 6,
  parameter int XO_START = 20
) (
  input  wire logic sys_clk,
  input  wire logic xtal_osc_enable,
  output var logic  rc_clk,
  output var logic  xt_clk,
  output var logic  xo_ready,
  output var logic  xo_ref
);
  timeunit 1ns;
  timeprecision 1ps;

  int rc_cnt = 0;
  int xt_cnt = 0;
  int xo_cnt = 0;

  // --------------------------------------------------------------------------
  // clock sources
  // --------------------------------------------------------------------------
  // start quiet so the synchronisers never see an unknown
  initial begin
    rc_clk = 1'b0;
    xt_clk = 1'b0;
    xo_ready = 1'b0;
    xo_ref = 1'b0;
  end

  // both slow sources run free; scaled far down to keep the run short
  always @(posedge sys_clk) begin
    rc_cnt <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
    xt_cnt <= (xt_cnt == XT_HALF - 1) ? 0 : xt_cnt + 1;
    if (rc_cnt == RC_HALF - 1) rc_clk <= ~rc_clk;
    if (xt_cnt == XT_HALF - 1) xt_clk <= ~xt_clk;
  end

  // crystal needs a start-up time; its reference stands still while it is off
  always @(posedge sys_clk) begin
    if (!xtal_osc_enable) begin
      xo_cnt <= 0;
      xo_ready <= 1'b0;
      xo_ref <= 1'b0;
    end else begin
      xo_cnt <= xo_cnt + 1;
      xo_ready <= (xo_cnt >= XO_START);
      if (xo_ready) xo_ref <= ~xo_ref;
    end
  end
endmodule : wt_partner

`default_nettype wire

// *** wt_top_bench.sv ***
// self-checking bench: wake periods, battery check, duty-cycle receive, calibration
`default_nettype none
`include "wt_defines.svh"

module wt_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        rc_clk, xt_clk, xo_rdy, xo_ref, xo_en;
  logic        src = 1'b0, wt_en = 1'b0, wie = 1'b0, bie = 1'b0, b2g = 1'b0;
  logic        duty = 1'b0, bmon = 1'b0, recal = 1'b0, armed = 1'b0, low;
  logic [4:0]  expo = 5'h00, bcode = 5'h00, pul = 5'h00;
  logic [15:0] mant = 16'h0000;
  logic [7:0]  win = 8'h01;
  logic [11:0] supply = 12'h0000;
  logic [2:0]  rfield = 3'h0;
  logic        irq_n, wflag, bflag, bgpio, rx_en, cal_o;
  logic [6:0]  rc_trim;
  logic [6:0]  trim = `WT_TRIM_RESET;
  logic [12:0] obs;
  logic [12:0] notes[$];
  int          num_errors = 0, check_count = 0, n, d, m, thr;

  assign obs = {cal_o, irq_n, wflag, bflag, bgpio, rx_en, rc_trim};
  always #5 sys_clk = ~sys_clk;

  wt_partner wt_partner_inst (.sys_clk(sys_clk), .xtal_osc_enable(xo_en), .rc_clk(rc_clk),
    .xt_clk(xt_clk), .xo_ready(xo_rdy), .xo_ref(xo_ref));

  wt_top wt_top_inst (.sys_clk(sys_clk), .rst(rst), .rc_clk_in(rc_clk), .xtal32_clk_in(xt_clk),
    .clock_source_select(src), .wake_timer_enable_bit(wt_en), .wake_period_exponent(expo),
    .wake_period_mantissa(mant), .wake_int_enable(wie), .battery_int_enable(bie),
    .battery_to_gpio(b2g), .duty_cycle_receive(duty), .receive_window_count(win),
    .battery_monitor_enable(bmon), .battery_threshold_setting(bcode), .supply_mv(supply),
    .boot_cmd(pul[0]), .shutdown_exit(pul[1]), .recal_enable(recal),
    .recalibration_interval_field(rfield), .xo_ready_in(xo_rdy), .xo_ref_clk_in(xo_ref),
    .preamble_or_sync_detect(pul[3]), .packet_received(pul[4]),
    .interrupt_status_clear(pul[2]), .interrupt_request_n(irq_n), .wake_timer_flag(wflag),
    .battery_low_flag(bflag), .battery_low_gpio(bgpio), .rx_enable(rx_en),
    .xtal_osc_enable(xo_en), .rc_trim(rc_trim), .calibrating(cal_o));

  // --------------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [12:0] note(input logic q, f, b, g, r);
    return {1'b0, q, f, b, g, r, trim};
  endfunction : note

  // bounded wait on one observed bit; running out counts as a mismatch
  task automatic wait_for(input int b, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (obs[b] !== v && cnt < lim) begin
      @(negedge sys_clk);
      cnt++;
    end
    if (obs[b] !== v) check(13'(obs[b]), 13'(v));
  endtask : wait_for

  task automatic pulse(input logic [4:0] p);
    pul = p;
    @(negedge sys_clk);
    pul = 5'h00;
  endtask : pulse

  // enable a few cycles after a slow edge, so no tick is in the synchroniser
  task automatic arm(input logic s, input logic [4:0] e, input logic [15:0] mt);
    src = s;
    expo = e;
    mant = mt;
    if (s) @(posedge xt_clk);
    else @(posedge rc_clk);
    repeat (5) @(negedge sys_clk);
    wt_en = 1'b1;
  endtask : arm

  task automatic stop;
    wt_en = 1'b0;
    pulse(5'h04);
    check(obs[10:8], 3'h0);
  endtask : stop

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // --------------------------------------------------------------------------
  // result watcher: each wake flag rise, receive end or calibration end takes a note
  // --------------------------------------------------------------------------
  initial begin
    wait (armed);
    forever begin
      @(posedge obs[10] or negedge obs[7] or negedge obs[12]);
      @(negedge sys_clk);
      if (notes.size() == 0) check(obs, ~obs);
      else check(obs, notes.pop_front());
    end
  end

  // watchdog, well beyond the shortest recalibration interval
  initial begin
    repeat (60000) @(posedge sys_clk);
    num_errors++;
    complete_run();
  end

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    void'($urandom(92647));
    repeat (10) @(negedge sys_clk);
    check(obs, note(1, 0, 0, 0, 0));
    rst = 1'b0;
    armed = 1'b1;
    // rc period with interrupt, then the automatic reload
    wie = 1'b1;
    m = 2 + $urandom % 3;
    notes.push_back(note(0, 1, 0, 0, 0));
    arm(1'b0, 5'h00, 16'(m));
    wait_for(10, 1'b1, 200, n);
    check(13'((n + 4) / 8), 13'(4 * m));
    pulse(5'h04);
    check(obs[11:10], 2'b10);
    notes.push_back(note(0, 1, 0, 0, 0));
    wait_for(10, 1'b1, 200, n);
    check(13'((n + 5) / 8), 13'(4 * m));
    stop();
    // crystal source, exponent 1, interrupt masked
    wie = 1'b0;
    notes.push_back(note(1, 1, 0, 0, 0));
    arm(1'b1, 5'h01, 16'h0002);
    wait_for(10, 1'b1, 400, n);
    check(13'((n + 6) / 12), 13'h0010);
    stop();
    $display("test wake_period done");
    // supply around the threshold, routing of the result drawn at random
    for (int i = 0; i < 8; i++) begin
      bcode = 5'($urandom % 32);
      thr = `WT_BATT_BASE_MV + `WT_BATT_STEP_MV * bcode;
      supply = 12'(thr - 1 + $urandom % 3);
      {bmon, bie, b2g} = 3'($urandom % 8);
      low = bmon && (supply < thr);
      notes.push_back(note(!(low && bie && !b2g), 1, low, low && b2g, 0));
      arm(1'b0, 5'h00, 16'h0001);
      wait_for(10, 1'b1, 100, n);
      stop();
    end
    bmon = 1'b0;
    $display("test battery done");
    // plain window, window extended by detection, window cut by a packet
    duty = 1'b1;
    win = 8'h03;
    for (int c = 0; c < 3; c++) begin
      notes.push_back(note(1, 1, 0, 0, 1));
      arm(1'b0, 5'h00, 16'h0020);
      wait_for(10, 1'b1, 1100, n);
      notes.push_back(note(1, 1, 0, 0, 0));
      d = 0;
      if (c > 0) begin
        repeat (10) @(negedge sys_clk);
        pulse(c == 1 ? 5'h08 : 5'h10);
        d = 11;
      end
      if (c == 1) begin
        repeat (89) @(negedge sys_clk);
        pulse(5'h08);
        d = 101;
      end
      wait_for(7, 1'b0, 400, n);
      d += n;
      if (c == 2) check(13'(d < 13), 13'h0001);
      else check(13'((d + 4) / 8), 13'(12 * (c + 1)));
      stop();
    end
    duty = 1'b0;
    $display("test duty_cycle done");
    // boot calibration; the fast rc reads as fast, so the trim steps down
    trim = trim - 7'h01;
    notes.push_back(note(1, 0, 0, 0, 0));
    pulse(5'h01);
    check(obs[12], 1'b1);
    wait_for(12, 1'b0, 3000, n);
    // shutdown exit, with a boot request dropped mid-run
    trim = trim - 7'h01;
    notes.push_back(note(1, 0, 0, 0, 0));
    pulse(5'h02);
    check(obs[12], 1'b1);
    repeat (50) @(negedge sys_clk);
    pulse(5'h01);
    wait_for(12, 1'b0, 3000, n);
    repeat (400) @(negedge sys_clk);
    check(13'(notes.size()), 13'h0000);
    // periodic recalibration at the shortest interval
    trim = trim - 7'h01;
    notes.push_back(note(1, 0, 0, 0, 0));
    recal = 1'b1;
    wait_for(12, 1'b1, 20000, n);
    wait_for(12, 1'b0, 3000, n);
    recal = 1'b0;
    // let the watcher take its note at this edge before the queue is counted
    repeat (2) @(negedge sys_clk);
    check(13'(notes.size()), 13'h0000);
    $display("test calibration done");
    complete_run();
  end
endmodule : wt_top_bench

`default_nettype wire
